// ---- core/pgc_pkg.sv ----
package pgc_pkg;

    // ****************************************************************
    // Command codes and register resets
    // ****************************************************************
    localparam int          PGC_NUM_CH        = 8;
    localparam logic [7:0]  PGC_CMD_PAGE      = 8'h00;
    localparam logic [7:0]  PGC_CMD_OPERATION = 8'h01;
    localparam logic [7:0]  PGC_CMD_ONOFF_CFG = 8'h02;
    localparam logic [7:0]  PGC_CMD_GW_MASK   = 8'he4;
    localparam logic [7:0]  PGC_PAGE_GLOBAL   = 8'hff;
    localparam logic [7:0]  PGC_PAGE_LAST     = 8'h07;
    localparam logic [7:0]  PGC_PAGE_RST      = 8'h00;
    localparam logic [7:0]  PGC_MASK_RST      = 8'hff;
    localparam logic [7:0]  PGC_OP_RST        = 8'h00;
    localparam logic [7:0]  PGC_CFG_RST       = 8'h1e;
    localparam logic [7:0]  PGC_UNDEF_DATA    = 8'h00;

    // ****************************************************************
    // Field encodings
    // ****************************************************************
    localparam logic [1:0]  PGC_CTRL_OFF      = 2'h0;
    localparam logic [1:0]  PGC_CTRL_SEQ_OFF  = 2'h1;
    localparam logic [1:0]  PGC_CTRL_ON       = 2'h2;
    localparam logic [1:0]  PGC_MARGIN_NOM    = 2'h0;
    localparam logic [1:0]  PGC_MARGIN_LOW    = 2'h1;
    localparam logic [1:0]  PGC_MARGIN_HIGH   = 2'h2;
    localparam logic [1:0]  PGC_FAULT_IGNORE  = 2'h1;
    localparam logic [1:0]  PGC_FAULT_NORMAL  = 2'h2;
    localparam logic [1:0]  PGC_OP_RSVD_VAL   = 2'h0;
    localparam logic [2:0]  PGC_CFG_RSVD_VAL  = 3'h0;
    localparam logic        PGC_CFG_FIXED_ONE = 1'b1;

    // Layout of the output operation byte, bit 7 first.
    typedef struct packed {
        logic [1:0] ctrl;
        logic [1:0] margin;
        logic [1:0] fault;
        logic [1:0] rsvd;
    } pgc_op_t;

    // Layout of the power-enable source configuration byte, bit 7 first.
    typedef struct packed {
        logic [2:0] rsvd;
        logic       controlled_on;
        logic       use_serial;
        logic       use_pin;
        logic       fixed_one;
        logic       fast_off;
    } pgc_cfg_t;

    // Command request from the serial front end.
    typedef struct packed {
        logic       valid;
        logic       write;
        logic [7:0] code;
        logic [7:0] data;
    } pgc_req_t;

    // Read answer back to the serial front end.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } pgc_rsp_t;

    // Per-channel power control outputs.
    typedef struct packed {
        logic       on_req;
        logic       off_now;
        logic       no_sink;
        logic [1:0] margin;
        logic       ignore_faults;
    } pgc_chan_t;

endpackage : pgc_pkg

// ---- core/pgc_channel.sv ----
`timescale 1ns/1ns

module pgc_channel
    import pgc_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      resetn,
    input  wire logic      clk_en,
    input  wire logic      wr_op,
    input  wire logic      wr_cfg,
    input  wire logic [7:0] wr_data,
    input  wire logic      pin_on,
    output logic [7:0]     op_rd,
    output logic [7:0]     cfg_rd,
    output pgc_chan_t      chan
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        pgc_op_t  op;
        pgc_cfg_t cfg;
    } pgc_ch_state_t;

    pgc_ch_state_t st;
    pgc_ch_state_t next_st;
    pgc_cfg_t      wr_cfg_val;
    logic          serial_ok;
    logic          pin_ok;

    // Only the live bits of the configuration byte are stored.
    always_comb begin
        wr_cfg_val           = pgc_cfg_t'(wr_data);
        next_st              = st;
        if (wr_op) begin
            next_st.op = pgc_op_t'(wr_data);
        end
        if (wr_cfg) begin
            next_st.cfg.controlled_on = wr_cfg_val.controlled_on;
            next_st.cfg.use_serial    = wr_cfg_val.use_serial;
            next_st.cfg.use_pin       = wr_cfg_val.use_pin;
            next_st.cfg.fast_off      = wr_cfg_val.fast_off;
        end
        next_st.cfg.rsvd      = PGC_CFG_RSVD_VAL;
        next_st.cfg.fixed_one = PGC_CFG_FIXED_ONE;
    end

    // Clock enable freezes the channel registers.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st <= {pgc_op_t'(PGC_OP_RST), pgc_cfg_t'(PGC_CFG_RST)};
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // On/off decision
    // ****************************************************************
    // With controlled-on set, each enabled source must agree and at least one must be enabled; a disabled source counts as true.
    always_comb begin
        serial_ok          = !st.cfg.use_serial || (st.op.ctrl == PGC_CTRL_ON);
        pin_ok             = !st.cfg.use_pin || pin_on;
        chan.on_req        = !st.cfg.controlled_on ||
                             ((st.cfg.use_serial || st.cfg.use_pin) &&
                              serial_ok && pin_ok);
        // Serial off with code 00 skips the sequencer; code 01 uses it.
        chan.off_now       = st.cfg.use_serial && (st.op.ctrl == PGC_CTRL_OFF);
        // A dropped pin with fast-off set stops drive but never sinks current.
        chan.no_sink       = st.cfg.use_pin && !pin_on && st.cfg.fast_off;
        chan.margin        = st.op.margin;
        chan.ignore_faults = (st.op.fault == PGC_FAULT_IGNORE);
    end

    assign op_rd  = st.op;
    assign cfg_rd = st.cfg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_auto_power_up: assert property (@(posedge mclk) disable iff (!resetn)
        !st.cfg.controlled_on |-> chan.on_req)
        else $error("Autonomous channel is not requesting power.");

    a_no_source_off: assert property (@(posedge mclk) disable iff (!resetn)
        (st.cfg.controlled_on && !st.cfg.use_serial && !st.cfg.use_pin) |-> !chan.on_req)
        else $error("Channel with no source enabled requests power.");

    a_pin_gates_on: assert property (@(posedge mclk) disable iff (!resetn)
        (st.cfg.controlled_on && st.cfg.use_pin && !pin_on) |-> !chan.on_req)
        else $error("Channel on while its enable pin is low.");

    a_both_sources: assert property (@(posedge mclk) disable iff (!resetn)
        (st.cfg.controlled_on && st.cfg.use_serial && st.cfg.use_pin)
        |-> chan.on_req == ((st.op.ctrl == PGC_CTRL_ON) && pin_on))
        else $error("Both-source channel does not follow command and pin.");

    a_cfg_fixed_bits: assert property (@(posedge mclk) disable iff (!resetn)
        (cfg_rd[7:5] == 3'h0) && cfg_rd[1])
        else $error("Configuration fixed bits read wrong.");

    a_cfg_write_kept: assert property (@(posedge mclk) disable iff (!resetn)
        (clk_en && wr_cfg) |=> (cfg_rd[4:2] == $past(wr_data[4:2])) && cfg_rd[1])
        else $error("Configuration write not stored.");

    c_channel_on: cover property (@(posedge mclk) disable iff (!resetn)
        st.cfg.controlled_on && st.cfg.use_serial && st.cfg.use_pin && chan.on_req);

endmodule : pgc_channel

// ---- core/pgc_page_ctrl.sv ----
`timescale 1ns/1ns

// Contract
// - Global page writes of global-capable commands reach all mask-selected channels together.
// - Only page, operation and source configuration accept writes under the global page.
// - Reads under the global page return undefined data and flag a fault.
// - Pages zero to seven route paged commands to that channel.
// - Serial control field: 00 off now, 10 on, 01 sequenced off.
// - Margin field picks nominal, low or high; fault field ignore or normal.
// - Without serial control, control field has no on/off effect.
// - Three upper configuration bits ignore writes and read zero.
// - Controlled-on clear powers up autonomously with sequencing.
// - Controlled-on set needs enabled sources; no sources means never on.
// - Serial-source clear ignores the control field.
// - Pin-source set needs pin asserted; clear ignores the pin.
// - Both sources set need on command and asserted pin.
// - Configuration bit one always reads one.
// - Pin drop with fast-off clear uses the turn-off delay.
// - Pin drop with fast-off set stops fast without sinking current.
// - Mask register, reset all ones, picks channels taking global writes.

module pgc_page_ctrl
    import pgc_pkg::*;
(
    input  wire logic                    mclk,
    input  wire logic                    resetn,
    input  wire logic                    clk_en,
    input  pgc_req_t                     req,
    output pgc_rsp_t                     rsp,
    input  wire logic                    fault_clear,
    output logic                         comm_fault,
    input  wire logic [PGC_NUM_CH-1:0]   channel_enable_pin,
    output pgc_chan_t [PGC_NUM_CH-1:0]   chan
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]            page;
        logic [7:0]            mask;
        logic [PGC_NUM_CH-1:0] pin_s1;
        logic [PGC_NUM_CH-1:0] pin_s2;
        pgc_rsp_t              rsp;
        logic                  fault;
    } pgc_state_t;

    pgc_state_t            st;
    pgc_state_t            next_st;
    logic [PGC_NUM_CH-1:0] wr_op_en;
    logic [PGC_NUM_CH-1:0] wr_cfg_en;
    logic [PGC_NUM_CH-1:0] target;
    logic [7:0]            op_rd  [PGC_NUM_CH];
    logic [7:0]            cfg_rd [PGC_NUM_CH];
    logic                  page_global;
    logic                  page_legal;
    logic                  op_legal;
    logic                  data_page_legal;
    logic                  do_write;
    logic                  do_read;
    logic                  set_fault;
    logic [7:0]            read_val;
    pgc_op_t               op_in;

    // ****************************************************************
    // Request decode
    // ****************************************************************
    // Validity checks on the current page and on the incoming byte.
    always_comb begin
        op_in           = pgc_op_t'(req.data);
        page_global     = (st.page == PGC_PAGE_GLOBAL);
        page_legal      = (st.page <= PGC_PAGE_LAST);
        data_page_legal = (req.data <= PGC_PAGE_LAST) ||
                          (req.data == PGC_PAGE_GLOBAL);
        // Control 11, margin 11, reserved low bits, or a margin without a
        // valid fault field are all reserved encodings.
        op_legal        = (op_in.ctrl != 2'h3) &&
                          (op_in.rsvd == PGC_OP_RSVD_VAL) &&
                          ((op_in.margin == PGC_MARGIN_NOM) ||
                           (((op_in.margin == PGC_MARGIN_LOW) ||
                             (op_in.margin == PGC_MARGIN_HIGH)) &&
                            ((op_in.fault == PGC_FAULT_IGNORE) ||
                             (op_in.fault == PGC_FAULT_NORMAL))));
        do_write        = req.valid && req.write;
        do_read         = req.valid && !req.write;
    end

    // Channel targets: one channel on a numbered page, the masked set on
    // the global page, none on a reserved page left over from reset paths.
    always_comb begin
        target = '0;
        if (page_global) begin
            target = st.mask;
        end else if (page_legal) begin
            target = PGC_NUM_CH'(1) << st.page[2:0];
        end
    end

    // Write strobes go to every targeted channel in the same edge.
    always_comb begin
        wr_op_en  = '0;
        wr_cfg_en = '0;
        if (do_write && (req.code == PGC_CMD_OPERATION) && op_legal) begin
            wr_op_en = target;
        end
        if (do_write && (req.code == PGC_CMD_ONOFF_CFG)) begin
            wr_cfg_en = target;
        end
    end

    // ****************************************************************
    // Read mux and fault detection
    // ****************************************************************
    // Reads under the global page answer a fixed pattern, since no single
    // channel owns the value; the host must treat it as meaningless.
    always_comb begin
        read_val  = PGC_UNDEF_DATA;
        set_fault = 1'b0;
        if (do_read) begin
            if (page_global) begin
                set_fault = 1'b1;
            end else begin
                unique case (req.code)
                    PGC_CMD_PAGE:      read_val = st.page;
                    PGC_CMD_GW_MASK:   read_val = st.mask;
                    PGC_CMD_OPERATION: read_val = op_rd[st.page[2:0]];
                    PGC_CMD_ONOFF_CFG: read_val = cfg_rd[st.page[2:0]];
                    default:           set_fault = 1'b1;
                endcase
            end
        end
        if (do_write) begin
            unique case (req.code)
                PGC_CMD_PAGE:      set_fault = !data_page_legal;
                PGC_CMD_OPERATION: set_fault = !op_legal;
                PGC_CMD_ONOFF_CFG: set_fault = 1'b0;
                PGC_CMD_GW_MASK:   set_fault = page_global;
                default:           set_fault = 1'b1;
            endcase
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    // The fault flag is sticky; a new fault in the clearing cycle wins so
    // that no event is lost.
    always_comb begin
        next_st           = st;
        next_st.pin_s1    = channel_enable_pin;
        next_st.pin_s2    = st.pin_s1;
        next_st.rsp.valid = do_read;
        next_st.rsp.data  = read_val;
        if (do_write && (req.code == PGC_CMD_PAGE) && data_page_legal) begin
            next_st.page = req.data;
        end
        if (do_write && (req.code == PGC_CMD_GW_MASK) && !page_global) begin
            next_st.mask = req.data;
        end
        if (set_fault) begin
            next_st.fault = 1'b1;
        end else if (fault_clear) begin
            next_st.fault = 1'b0;
        end
    end

    // One register stage for the whole controller; clock enable freezes it.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            st         <= '0;
            st.page    <= PGC_PAGE_RST;
            st.mask    <= PGC_MASK_RST;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign rsp        = st.rsp;
    assign comm_fault = st.fault;

    // ****************************************************************
    // Channels
    // ****************************************************************
    // Write strobes are qualified by the clock enable inside each channel.
    for (genvar i = 0; i < PGC_NUM_CH; i++) begin : g_chan
        pgc_channel u_chan (
            .mclk    (mclk),
            .resetn  (resetn),
            .clk_en  (clk_en),
            .wr_op   (wr_op_en[i]),
            .wr_cfg  (wr_cfg_en[i]),
            .wr_data (req.data),
            .pin_on  (st.pin_s2[i]),
            .op_rd   (op_rd[i]),
            .cfg_rd  (cfg_rd[i]),
            .chan    (chan[i])
        );
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_global_fanout: assert property (@(posedge mclk) disable iff (!resetn)
        (do_write && page_global && (req.code == PGC_CMD_ONOFF_CFG)) |-> (wr_cfg_en == st.mask))
        else $error("Global configuration write missed masked channels.");

    a_global_only_two: assert property (@(posedge mclk) disable iff (!resetn)
        (do_write && page_global && (req.code == PGC_CMD_GW_MASK) && clk_en)
        |=> (st.mask == $past(st.mask)) && st.fault)
        else $error("Non-global command accepted under the global page.");

    a_global_read_flt: assert property (@(posedge mclk) disable iff (!resetn)
        (do_read && page_global && clk_en) |=> st.fault && st.rsp.valid)
        else $error("Global page read did not flag a fault.");

    a_page_routing: assert property (@(posedge mclk) disable iff (!resetn)
        (do_write && page_legal && (req.code == PGC_CMD_OPERATION) && op_legal)
        |-> (wr_op_en == (PGC_NUM_CH'(1) << st.page[2:0])))
        else $error("Paged operation write went to the wrong channel.");

    a_page_reject: assert property (@(posedge mclk) disable iff (!resetn)
        (do_write && (req.code == PGC_CMD_PAGE) && !data_page_legal && clk_en)
        |=> (st.page == $past(st.page)) && st.fault)
        else $error("Reserved page value was not rejected.");

    a_op_reject: assert property (@(posedge mclk) disable iff (!resetn)
        (do_write && (req.code == PGC_CMD_OPERATION) && !op_legal) |-> (wr_op_en == '0))
        else $error("Reserved operation value reached a channel.");

    a_mask_reset: assert property (@(posedge mclk)
        !resetn |=> (st.mask == PGC_MASK_RST) && (st.page == PGC_PAGE_RST))
        else $error("Mask or page reset value wrong.");

    a_fault_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        (st.fault && !fault_clear) |=> st.fault)
        else $error("Fault flag dropped without a clear.");

    c_global_write: cover property (@(posedge mclk) disable iff (!resetn)
        do_write && page_global && (req.code == PGC_CMD_OPERATION) && op_legal && clk_en);

    c_global_read: cover property (@(posedge mclk) disable iff (!resetn)
        do_read && page_global && clk_en);

    c_page_switch: cover property (@(posedge mclk) disable iff (!resetn)
        (st.page == PGC_PAGE_LAST) ##1 page_global);

endmodule : pgc_page_ctrl

// ---- verification/pgc_host.sv ----
`timescale 1ns/1ns

// ****************************************************************
// Host side of the command port
// ****************************************************************
module pgc_host
    import pgc_pkg::*;
(
    input  wire logic     mclk,
    input  wire pgc_rsp_t rsp,
    output pgc_req_t      req
);

    // The port starts idle so that no request can be taken during reset.
    initial begin
        req = '0;
    end

    // The request stands until the edge that takes it. Afterwards the idle lines show the
    // inverse of the last byte, so that a stale byte can never pass for a fresh one.
    // Page values stay within 00..07 or ff unless the caller wants a refusal.
    task automatic send(input logic w, input logic [7:0] code, input logic [7:0] data);
        @(posedge mclk);
        req <= '{1'b1, w, code, data};
        @(posedge mclk);
        req <= '{1'b0, 1'b0, ~code, ~data};
    endtask : send

    // The answer is registered on the taking edge, so it is looked at just after it.
    task automatic fetch(input logic [7:0] code, output logic vld, output logic [7:0] data);
        send(1'b0, code, 8'h00);
        #1;
        vld = rsp.valid;
        data = rsp.data;
    endtask : fetch

endmodule : pgc_host

// ---- verification/testbench.sv ----
`timescale 1ns/1ns

module testbench import pgc_pkg::*;;

    logic                       mclk;
    logic                       resetn;
    logic                       clk_en;
    logic                       fault_clear;
    logic                       comm_fault;
    logic [PGC_NUM_CH-1:0]      pins;
    pgc_req_t                   req;
    pgc_rsp_t                   rsp;
    pgc_chan_t [PGC_NUM_CH-1:0] chan;
    int                         errors;
    int                         comparisons;
    logic                       rv;
    logic [7:0]                 rd;
    logic [7:0]                 ops [8] = '{8'h00, 8'h40, 8'h80, 8'h94, 8'h98, 8'ha4, 8'ha8, 8'h54};
    logic [7:0]                 bad [4] = '{8'hc0, 8'h81, 8'hb8, 8'h90};

    pgc_page_ctrl dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .req(req), .rsp(rsp),
                       .fault_clear(fault_clear), .comm_fault(comm_fault),
                       .channel_enable_pin(pins), .chan(chan));
    pgc_host host (.mclk(mclk), .rsp(rsp), .req(req));

    // ****************************************************************
    // Clock, checking and closing
    // ****************************************************************
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    task automatic wr(input logic [7:0] code, input logic [7:0] data);
        host.send(1'b1, code, data);
    endtask : wr

    task automatic rdchk(input string what, input logic [7:0] code, input logic [7:0] exp);
        host.fetch(code, rv, rd);
        check("rsp valid", rv, 8'h01);
        check(what, rd, exp);
    endtask : rdchk

    // Pins pass two synchroniser flops, so three edges leave one spare.
    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask : settle

    // A fault must be raised already; one cycle of clear must drop it.
    task automatic clear_fault();
        check("fault set", comm_fault, 8'h01);
        @(posedge mclk);
        fault_clear <= 1'b1;
        @(posedge mclk);
        fault_clear <= 1'b0;
        #1;
        check("fault cleared", comm_fault, 8'h00);
    endtask : clear_fault

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        #1;
        check("fault", comm_fault, 8'h00);
        check("off_now", chan[0].off_now, 8'h01);
        rdchk("page", PGC_CMD_PAGE, 8'h00);
        rdchk("mask", PGC_CMD_GW_MASK, 8'hff);
        rdchk("cfg", PGC_CMD_ONOFF_CFG, 8'h1e);
    endtask : t_reset

    // Every channel gets its own operation byte, so a wrong route shows in the read-back.
    task automatic t_paging();
        for (int i = 0; i < 8; i++) begin
            wr(PGC_CMD_PAGE, 8'(i));
            wr(PGC_CMD_OPERATION, ops[i]);
        end
        settle();
        check("fault", comm_fault, 8'h00);
        for (int i = 0; i < 8; i++) begin
            check("margin", chan[i].margin, ops[i][5:4]);
            check("ignore", chan[i].ignore_faults, ops[i][3:2] == 2'b01);
            wr(PGC_CMD_PAGE, 8'(i));
            rdchk("op", PGC_CMD_OPERATION, ops[i]);
        end
    endtask : t_paging

    // All source selections, the off-now and on control codes and both pin levels on channel 0.
    // Autonomous power-up carries no delay here, as a host gets with a zero turn-on delay.
    task automatic t_onoff();
        logic [7:0] cfg;
        logic       exp_on;
        wr(PGC_CMD_PAGE, 8'h00);
        for (int k = 0; k < 64; k++) begin
            cfg = {3'b111, k[3:1], 1'b0, k[0]};
            wr(PGC_CMD_ONOFF_CFG, cfg);
            wr(PGC_CMD_OPERATION, k[4] ? 8'h80 : 8'h00);
            pins <= {8{k[5]}};
            settle();
            exp_on = !cfg[4] | ((cfg[3] | cfg[2]) & (!cfg[3] | k[4]) & (!cfg[2] | k[5]));
            check("on_req", chan[0].on_req, exp_on);
            if (cfg[4]) begin
                check("off_now", chan[0].off_now, cfg[3] & !k[4]);
                check("no_sink", chan[0].no_sink, cfg[2] & cfg[0] & !k[5]);
            end
            rdchk("cfg", PGC_CMD_ONOFF_CFG, {3'b000, cfg[4:2], 1'b1, cfg[0]});
        end
    endtask : t_onoff

    task automatic t_global();
        for (int i = 0; i < 8; i++) begin
            wr(PGC_CMD_PAGE, 8'(i));
            wr(PGC_CMD_OPERATION, 8'h00);
        end
        wr(PGC_CMD_GW_MASK, 8'h5a);
        wr(PGC_CMD_PAGE, PGC_PAGE_GLOBAL);
        wr(PGC_CMD_OPERATION, 8'ha8);
        wr(PGC_CMD_ONOFF_CFG, 8'h0e);
        settle();
        check("fault", comm_fault, 8'h00);
        for (int i = 0; i < 8; i++) begin
            check("margin", chan[i].margin, 8'h5a >> i & 8'h01 ? 8'h02 : 8'h00);
            check("on_req", chan[i].on_req, 8'h5a >> i & 8'h01);
        end
        host.fetch(PGC_CMD_OPERATION, rv, rd);
        check("global valid", rv, 8'h01);
        check("global read", rd, 8'h00);
        settle();
        clear_fault();
        wr(PGC_CMD_GW_MASK, 8'hff);
        settle();
        clear_fault();
        wr(PGC_CMD_PAGE, 8'h00);
        rdchk("mask", PGC_CMD_GW_MASK, 8'h5a);
    endtask : t_global

    // Reserved encodings change nothing and leave a fault behind.
    task automatic t_refuse();
        wr(PGC_CMD_PAGE, 8'h08);
        settle();
        clear_fault();
        rdchk("page", PGC_CMD_PAGE, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(PGC_CMD_OPERATION, bad[i]);
            settle();
            clear_fault();
            rdchk("op", PGC_CMD_OPERATION, 8'h00);
        end
    endtask : t_refuse

    // A request made while the clock enable is low must leave no trace.
    task automatic t_freeze();
        @(posedge mclk);
        clk_en <= 1'b0;
        wr(PGC_CMD_PAGE, 8'h03);
        clk_en <= 1'b1;
        settle();
        check("frozen fault", comm_fault, 8'h00);
        rdchk("frozen page", PGC_CMD_PAGE, 8'h00);
    endtask : t_freeze

    // ****************************************************************
    // Main sequence and watchdog
    // ****************************************************************
    initial begin
        clk_en = 1'b1;
        resetn = 1'b0;
        fault_clear = 1'b0;
        pins = '0;
        errors = 0;
        comparisons = 0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_paging();
        t_onoff();
        t_global();
        t_refuse();
        t_freeze();
        results();
    end

    // The tests need under a thousand cycles; twenty times that means a hang.
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        results();
    end

endmodule : testbench
